// file: mto_option_ctrl.sv
// Option control of a triangular-wave motor PWM timer behind an APB slave.
// Assumes phase outputs and auxiliary match pulses come from logic on clk; events are one-cycle.
`timescale 1ns/10ps
`include "mto_params.svh"

module mto_option_ctrl import mto_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16,
  parameter int DT_W = 10,
  parameter int PHASES = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer side.
  input wire logic [PHASES-1:0] phaseOutput,
  input wire logic auxMatch0Irq,
  input wire logic auxMatch1Irq,
  // Interrupt and trigger outputs.
  output logic crestIrq,
  output logic valleyIrq,
  output logic adcTriggerOut0,
  // Compare register update control.
  output logic compareTransfer,
  output logic compareAnytime,
  // Arm outputs.
  output mto_arm_t [PHASES-1:0] armOut
);

  localparam logic [31:0] IDX_OPT0 = `MTO_IDX_OPT0;
  localparam logic [31:0] IDX_OPT1 = `MTO_IDX_OPT1;
  localparam logic [31:0] IDX_OPT2 = `MTO_IDX_OPT2;
  localparam logic [31:0] IDX_CTRL = `MTO_IDX_CTRL;
  localparam logic [31:0] IDX_PERIOD = `MTO_IDX_PERIOD;

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldW, input logic [31:0] newW,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldW;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newW[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register file state.
  logic cms_r, cms_nxt;
  mto_opt1_t opt1Buf_r, opt1Buf_nxt;
  mto_opt1_t opt1Act_r, opt1Act_nxt;
  mto_opt2_t opt2_r, opt2_nxt;
  logic run_r, run_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic [DT_W-1:0] dtc_r, dtc_nxt;
  logic [CNT_W-1:0] period_r, period_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  // Timer and event state.
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic dirDown_r, dirDown_nxt;
  logic crestEvt_r, crestEvt_nxt;
  logic valleyEvt_r, valleyEvt_nxt;
  logic runDly_r, runDly_nxt;
  logic [`MTO_CULL_W-1:0] cull_r, cull_nxt;
  logic crestIrq_r, crestIrq_nxt;
  logic valleyIrq_r, valleyIrq_nxt;
  logic adcTrig_r, adcTrig_nxt;
  logic xfer_r, xfer_nxt;
  logic anytime_r, anytime_nxt;

  logic hitOpt0, hitOpt1, hitOpt2, hitCtrl, hitPeriod, hitAny;
  logic wrEn, setup;
  logic [31:0] ctrlWord, ctrlMerged, periodMerged;
  logic sixPhase, anytime, dirFlag, cullEvent, cullPass, xferNow;
  logic [PHASES-1:0] dtUp, dtDown;
  logic aux0Ok, aux1Ok;

  // Bus decode; zero wait states, unmapped addresses answer with an error.
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign hitOpt0 = paddr[ADDR_W-1:2] == IDX_OPT0[ADDR_W-3:0];
  assign hitOpt1 = paddr[ADDR_W-1:2] == IDX_OPT1[ADDR_W-3:0];
  assign hitOpt2 = paddr[ADDR_W-1:2] == IDX_OPT2[ADDR_W-3:0];
  assign hitCtrl = paddr[ADDR_W-1:2] == IDX_CTRL[ADDR_W-3:0];
  assign hitPeriod = paddr[ADDR_W-1:2] == IDX_PERIOD[ADDR_W-3:0];
  assign hitAny = hitOpt0 || hitOpt1 || hitOpt2 || hitCtrl || hitPeriod;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  assign prdata = prdata_r;

  assign sixPhase = (mode_r == `MTO_MODE_SIX_PHASE);
  assign anytime = cms_r && sixPhase;
  assign dirFlag = dirDown_r && sixPhase;

  always_comb begin
    ctrlWord = `MTO_WORD_RESET;
    ctrlWord[`MTO_CTRL_RUN] = run_r;
    ctrlWord[`MTO_CTRL_MODE_MSB:`MTO_CTRL_MODE_LSB] = mode_r;
    ctrlWord[`MTO_CTRL_DTC_LSB +: DT_W] = dtc_r;
    ctrlMerged = mergeBytes(ctrlWord, pwdata, pstrb);
    periodMerged = mergeBytes({{(32-CNT_W){1'b0}}, period_r}, pwdata, pstrb);
  end

  // Register writes and read data.
  always_comb begin
    cms_nxt = cms_r;
    opt1Buf_nxt = opt1Buf_r;
    opt2_nxt = opt2_r;
    run_nxt = run_r;
    mode_nxt = mode_r;
    dtc_nxt = dtc_r;
    period_nxt = period_r;
    prdata_nxt = prdata_r;
    if (wrEn && pstrb[0]) begin
      if (hitOpt0) begin
        // Only the rewrite bit is stored; direction is read-only, upper bits read zero.
        cms_nxt = pwdata[`MTO_OPT0_CMS_BIT];
      end
      if (hitOpt1) begin
        opt1Buf_nxt = pwdata[7:0];
        opt1Buf_nxt.rsvd = 1'b0;
      end
      if (hitOpt2) begin
        opt2_nxt = pwdata[7:0];
      end
    end
    if (wrEn && hitCtrl) begin
      run_nxt = ctrlMerged[`MTO_CTRL_RUN];
      mode_nxt = ctrlMerged[`MTO_CTRL_MODE_MSB:`MTO_CTRL_MODE_LSB];
      dtc_nxt = ctrlMerged[`MTO_CTRL_DTC_LSB +: DT_W];
    end
    if (wrEn && hitPeriod) begin
      period_nxt = periodMerged[CNT_W-1:0];
    end
    if (setup && !pwrite) begin
      prdata_nxt = `MTO_WORD_RESET;
      if (hitOpt0) begin
        prdata_nxt[7:0] = mto_opt0_t'{rsvd: '0, cms: cms_r, cuf: dirFlag, ovf: 1'b0};
      end
      if (hitOpt1) begin
        prdata_nxt[7:0] = opt1Buf_r;
      end
      if (hitOpt2) begin
        prdata_nxt[7:0] = opt2_r;
      end
      if (hitCtrl) begin
        prdata_nxt = ctrlWord;
      end
      if (hitPeriod) begin
        prdata_nxt[CNT_W-1:0] = period_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cms_r <= 1'b0;
      opt1Buf_r <= `MTO_OPT_RESET;
      opt2_r <= `MTO_OPT_RESET;
      run_r <= 1'b0;
      mode_r <= `MTO_MODE_RESET;
      dtc_r <= '0;
      period_r <= '0;
      prdata_r <= `MTO_WORD_RESET;
    end else begin
      cms_r <= cms_nxt;
      opt1Buf_r <= opt1Buf_nxt;
      opt2_r <= opt2_nxt;
      run_r <= run_nxt;
      mode_r <= mode_nxt;
      dtc_r <= dtc_nxt;
      period_r <= period_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Triangular counter: up to the period, crest at the match, down to zero, valley there.
  always_comb begin
    cnt_nxt = cnt_r;
    dirDown_nxt = dirDown_r;
    crestEvt_nxt = 1'b0;
    valleyEvt_nxt = 1'b0;
    if (!run_r) begin
      cnt_nxt = '0;
      dirDown_nxt = 1'b0;
    end else if (!dirDown_r) begin
      if (cnt_r == period_r) begin
        crestEvt_nxt = 1'b1;
        dirDown_nxt = 1'b1;
        cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - CNT_W'(1);
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end else begin
      if (cnt_r == '0) begin
        valleyEvt_nxt = 1'b1;
        dirDown_nxt = 1'b0;
        cnt_nxt = (period_r == '0) ? cnt_r : cnt_r + CNT_W'(1);
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      dirDown_r <= 1'b0;
      crestEvt_r <= 1'b0;
      valleyEvt_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dirDown_r <= dirDown_nxt;
      crestEvt_r <= crestEvt_nxt;
      valleyEvt_r <= valleyEvt_nxt;
    end
  end

  // Dead-time counters, one per phase.
  for (genvar p = 0; p < PHASES; p++) begin : gPhase
    mto_deadtime #(.DT_W(DT_W)) uDeadtime (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(run_r),
      .narrowMode(opt2_r.dtNarrow),
      .dtCompare(dtc_r),
      .phaseIn(phaseOutput[p]),
      .armOut(armOut[p]),
      .countingUp(dtUp[p]),
      .countingDown(dtDown[p])
    );
  end

  // Culling, transfer and trigger generation.
  assign cullEvent = (crestEvt_r && opt1Act_r.crestEn) || (valleyEvt_r && opt1Act_r.valleyEn);
  assign cullPass = cullEvent && (cull_r == opt1Act_r.cullCount);
  assign xferNow = opt2_r.xferCullEn ? cullPass : (crestEvt_r || valleyEvt_r);
  assign aux1Ok = auxMatch1Irq && opt2_r.enAux1 && (opt2_r.phaseSelAux1 ? |dtDown : |dtUp);
  assign aux0Ok = auxMatch0Irq && opt2_r.enAux0 && (opt2_r.phaseSelAux0 ? |dtDown : |dtUp);

  always_comb begin
    runDly_nxt = run_r;
    cull_nxt = cull_r;
    if (run_r && !runDly_r) begin
      cull_nxt = '0;
    end else if (cullPass) begin
      cull_nxt = '0;
    end else if (cullEvent) begin
      cull_nxt = cull_r + `MTO_CULL_W'(1);
    end
    crestIrq_nxt = cullPass && crestEvt_r;
    valleyIrq_nxt = cullPass && valleyEvt_r;
    adcTrig_nxt = aux1Ok || aux0Ok || (crestIrq_nxt && opt2_r.enCrest)
                  || (valleyIrq_nxt && opt2_r.enValley);
    xfer_nxt = run_r && !anytime && xferNow;
    anytime_nxt = anytime;
    // Option one goes live at once when stopped or in anytime mode, else at the transfer.
    if (!run_r || anytime || xfer_nxt) begin
      opt1Act_nxt = opt1Buf_nxt;
    end else begin
      opt1Act_nxt = opt1Act_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      runDly_r <= 1'b0;
      cull_r <= '0;
      crestIrq_r <= 1'b0;
      valleyIrq_r <= 1'b0;
      adcTrig_r <= 1'b0;
      xfer_r <= 1'b0;
      anytime_r <= 1'b0;
      opt1Act_r <= `MTO_OPT_RESET;
    end else begin
      runDly_r <= runDly_nxt;
      cull_r <= cull_nxt;
      crestIrq_r <= crestIrq_nxt;
      valleyIrq_r <= valleyIrq_nxt;
      adcTrig_r <= adcTrig_nxt;
      xfer_r <= xfer_nxt;
      anytime_r <= anytime_nxt;
      opt1Act_r <= opt1Act_nxt;
    end
  end

  assign crestIrq = crestIrq_r;
  assign valleyIrq = valleyIrq_r;
  assign adcTriggerOut0 = adcTrig_r;
  assign compareTransfer = xfer_r;
  assign compareAnytime = anytime_r;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  opt_reset_zero_a: assert property ($past(sys_rst) |-> !cms_r && opt1Buf_r == '0 && opt2_r == '0)
    else $error("option registers not zero after reset");
  dir_after_crest_a: assert property (crestEvt_r && sixPhase |-> dirFlag && !valleyEvt_r)
    else $error("direction flag not down after crest");
  cull_zero_pass_a: assert property ((cullEvent && opt1Act_r.cullCount == '0) |=>
    (crestIrq_r || valleyIrq_r))
    else $error("event not passed with culling count zero");
  cull_count_a: assert property ((crestIrq_r || valleyIrq_r) |-> $past(cull_r) == $past(opt1Act_r.cullCount))
    else $error("culled event passed at wrong count");
  crest_masked_a: assert property (crestEvt_r && !opt1Act_r.crestEn |=> !crestIrq_r)
    else $error("disabled crest event reached interrupt");
  valley_masked_a: assert property (valleyEvt_r && !opt1Act_r.valleyEn |=> !valleyIrq_r)
    else $error("disabled valley event reached interrupt");
  trig_culled_only_a: assert property ((crestEvt_r || valleyEvt_r) && !cullPass && !auxMatch0Irq
    && !auxMatch1Irq |=> !adcTriggerOut0)
    else $error("trigger issued on a masked event");
  xfer_every_a: assert property (run_r && !anytime && !opt2_r.xferCullEn && (crestEvt_r || valleyEvt_r)
    |=> compareTransfer)
    else $error("transfer missing at crest or valley");
  anytime_live_a: assert property (run_r && anytime |=> opt1Act_r == opt1Buf_r)
    else $error("anytime mode did not apply option one");
  run_clears_cull_a: assert property ($rose(run_r) |=> cull_r == '0)
    else $error("culling counter not cleared at start");

endmodule

// file: mto_params.svh
// Register indices, reset values, field positions and mode codes of the motor timer option block.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef MTO_PARAMS_SVH
`define MTO_PARAMS_SVH

// Register indices; the bus byte address is four times the index.
`define MTO_IDX_OPT0 32'h0ffff605
`define MTO_IDX_OPT1 32'h0ffff620
`define MTO_IDX_OPT2 32'hfffff621
`define MTO_IDX_CTRL 32'h0ffff630
`define MTO_IDX_PERIOD 32'h0ffff631

// Reset values.
`define MTO_OPT_RESET 8'h00
`define MTO_MODE_RESET 3'h0
`define MTO_WORD_RESET 32'h00000000

// Timer mode code of the six-phase output mode.
`define MTO_MODE_SIX_PHASE 3'h7

// Field positions in the control register.
`define MTO_CTRL_RUN 0
`define MTO_CTRL_MODE_LSB 1
`define MTO_CTRL_MODE_MSB 3
`define MTO_CTRL_DTC_LSB 16

// Rewrite mode bit in option register zero.
`define MTO_OPT0_CMS_BIT 2

// Width of the culling count.
`define MTO_CULL_W 5

`endif

// file: mto_pkg.sv
// Types of the motor timer option block: option register layouts and dead-time states.
// Assumes nothing beyond a SystemVerilog compiler.
package mto_pkg;

  typedef struct packed {
    logic [4:0] rsvd;
    logic cms;
    logic cuf;
    logic ovf;
  } mto_opt0_t;

  typedef struct packed {
    logic crestEn;
    logic valleyEn;
    logic rsvd;
    logic [4:0] cullCount;
  } mto_opt1_t;

  typedef struct packed {
    logic xferCullEn;
    logic dtNarrow;
    logic phaseSelAux1;
    logic phaseSelAux0;
    logic enAux1;
    logic enAux0;
    logic enCrest;
    logic enValley;
  } mto_opt2_t;

  typedef struct packed {
    logic upper;
    logic lower;
  } mto_arm_t;

  typedef enum logic [2:0] {
    DT_IDLE = 3'b001,
    DT_UP = 3'b010,
    DT_DOWN = 3'b100
  } mto_dt_state_t;

endpackage

// file: mto_deadtime.sv
// One dead-time counter with its upper and lower arm outputs for a single phase.
// Assumes the phase input comes from logic on the same clock.
`timescale 1ns/10ps
`include "mto_params.svh"

module mto_deadtime import mto_pkg::*; #(
  parameter int DT_W = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic run,
  input wire logic narrowMode,
  input wire logic [DT_W-1:0] dtCompare,
  input wire logic phaseIn,
  // Outputs.
  output mto_arm_t armOut,
  output logic countingUp,
  output logic countingDown
);

  mto_dt_state_t state_r, state_nxt;
  logic [DT_W-1:0] cnt_r, cnt_nxt;
  logic phaseDly_r, phaseDly_nxt;
  mto_arm_t arm_r, arm_nxt;
  logic edgeSeen;

  assign edgeSeen = phaseIn ^ phaseDly_r;
  assign countingUp = (state_r == DT_UP);
  assign countingDown = (state_r == DT_DOWN);
  assign armOut = arm_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    phaseDly_nxt = phaseIn;
    arm_nxt = '{upper: 1'b0, lower: 1'b0};
    if (!run) begin
      // Stopped: no dead time, both arms at their initial low level.
      state_nxt = DT_IDLE;
      cnt_nxt = '0;
    end else if (dtCompare == '0) begin
      // No dead time wanted: arms follow the phase directly.
      state_nxt = DT_IDLE;
      cnt_nxt = '0;
      arm_nxt = '{upper: phaseIn, lower: !phaseIn};
    end else begin
      case (state_r)
        DT_IDLE: begin
          if (edgeSeen) begin
            state_nxt = DT_UP;
            cnt_nxt = '0;
          end else begin
            arm_nxt = '{upper: phaseIn, lower: !phaseIn};
          end
        end
        DT_UP: begin
          if (edgeSeen) begin
            if (narrowMode) begin
              state_nxt = DT_DOWN;
            end else begin
              cnt_nxt = '0;
            end
          end else if (cnt_r == dtCompare) begin
            state_nxt = DT_IDLE;
          end else begin
            cnt_nxt = cnt_r + DT_W'(1);
          end
        end
        DT_DOWN: begin
          // Counting down shortens the dead time of a pulse narrower than it.
          if (edgeSeen) begin
            state_nxt = DT_UP;
          end else if (cnt_r == '0) begin
            state_nxt = DT_IDLE;
          end else begin
            cnt_nxt = cnt_r - DT_W'(1);
          end
        end
        default: begin
          state_nxt = DT_IDLE;
          cnt_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= DT_IDLE;
      cnt_r <= '0;
      phaseDly_r <= 1'b0;
      arm_r <= '{upper: 1'b0, lower: 1'b0};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      phaseDly_r <= phaseDly_nxt;
      arm_r <= arm_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  arms_when_stopped_a: assert property (!run |=> !arm_r.upper && !arm_r.lower)
    else $error("arm output active while timer stopped");
  arms_never_overlap_a: assert property (!(arm_r.upper && arm_r.lower))
    else $error("upper and lower arm active together");
  narrow_counts_down_a: assert property (
    (run && dtCompare != '0 && state_r == DT_UP && edgeSeen && narrowMode)
      |=> state_r == DT_DOWN && cnt_r == $past(cnt_r))
    else $error("narrow pulse did not turn counter down");
  narrow_clear_a: assert property (
    (run && dtCompare != '0 && state_r == DT_UP && edgeSeen && !narrowMode)
      |=> state_r == DT_UP && cnt_r == '0)
    else $error("narrow pulse did not restart counter");

endmodule

// file: mto_event_sink.sv
// Far-side model: interrupt controller and A/D trigger inputs that count the block's pulses.
// Assumes every event output of the block is a one-cycle pulse on clk.
`timescale 1ns/10ps

module mto_event_sink (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic clrCnt,
  // Events from the block.
  input wire logic crestIrq,
  input wire logic valleyIrq,
  input wire logic adcTriggerOut0,
  input wire logic compareTransfer,
  // Counts: 0 crest, 1 valley, 2 trigger, 3 transfer.
  output logic [3:0][15:0] evCnt
);
  logic [3:0][15:0] cnt_r;
  logic [3:0][15:0] cnt_nxt;
  logic [3:0] ev;

  // A pulse is counted once per high cycle, so a stretched pulse shows up as extra events.
  assign ev = {compareTransfer, adcTriggerOut0, valleyIrq, crestIrq};
  assign evCnt = cnt_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cnt_nxt[i] = clrCnt ? 16'h0000 : cnt_r[i] + {15'h0000, ev[i]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: tb.sv
// Self-checking bench of the motor timer option block over APB.
// Assumes the default parameters of the block and the event counter model beside it.
`timescale 1ns/10ps
`include "mto_params.svh"

module tb import mto_pkg::*;;
  localparam logic [11:0] A_OPT0 = 12'(`MTO_IDX_OPT0 << 2);
  localparam logic [11:0] A_OPT1 = 12'(`MTO_IDX_OPT1 << 2);
  localparam logic [11:0] A_OPT2 = 12'(`MTO_IDX_OPT2 << 2);
  localparam logic [11:0] A_CTRL = 12'(`MTO_IDX_CTRL << 2);
  localparam logic [11:0] A_PER = 12'(`MTO_IDX_PERIOD << 2);

  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, cRef;
  logic [3:0] pstrb;
  logic [2:0] phaseOutput;
  logic auxMatch0Irq, auxMatch1Irq, crestIrq, valleyIrq, adcTriggerOut0;
  logic compareTransfer, compareAnytime, clrCnt, errv;
  mto_arm_t [2:0] armOut;
  logic [3:0][15:0] evCnt;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int n0, n1;
  logic [7:0] tSet [5] = '{8'h04, 8'h14, 8'h08, 8'h28, 8'h00};
  logic tAux [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [31:0] tExp [5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0};

  mto_option_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phaseOutput(phaseOutput),
    .auxMatch0Irq(auxMatch0Irq), .auxMatch1Irq(auxMatch1Irq), .crestIrq(crestIrq),
    .valleyIrq(valleyIrq), .adcTriggerOut0(adcTriggerOut0),
    .compareTransfer(compareTransfer), .compareAnytime(compareAnytime), .armOut(armOut));

  mto_event_sink sink_u (.clk(clk), .sys_rst(sys_rst), .clrCnt(clrCnt), .crestIrq(crestIrq),
    .valleyIrq(valleyIrq), .adcTriggerOut0(adcTriggerOut0),
    .compareTransfer(compareTransfer), .evCnt(evCnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The run is just over a thousand cycles; this ceiling only catches a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk("wait states", n, 32'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic clr();
    @(posedge clk);
    clrCnt <= 1'b1;
    @(posedge clk);
    clrCnt <= 1'b0;
  endtask

  // Runs the six-phase timer from a fresh start for a fixed span with the given options.
  task automatic window(input logic [7:0] o1, input logic [7:0] o2);
    apb(1'b1, A_OPT1, {24'h0, o1});
    apb(1'b1, A_OPT2, {24'h0, o2});
    clr();
    apb(1'b1, A_CTRL, 32'h0000000f);
    repeat (200) @(posedge clk);
    apb(1'b1, A_CTRL, 32'h0000000e);
    repeat (4) @(posedge clk);
  endtask

  // Sends a two-cycle high pulse on phase 0 and counts cycles until the lower arm is on.
  task automatic narrow(output int n);
    repeat (20) @(posedge clk);
    phaseOutput[0] <= 1'b1;
    repeat (2) @(posedge clk);
    phaseOutput[0] <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (armOut[0].lower !== 1'b1 && n < 60);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    phaseOutput = 3'h0;
    auxMatch0Irq = 1'b0;
    auxMatch1Irq = 1'b0;
    clrCnt = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (tSet[i]) begin
      apb(1'b0, (i == 0) ? A_OPT0 : (i == 1) ? A_OPT1 : A_OPT2, 32'h0);
      chk("option reset", rdv, 32'h0);
      if (i == 2) break;
    end
    apb(1'b1, A_OPT0, 32'h000000ff);
    apb(1'b0, A_OPT0, 32'h0);
    chk("option0 readback", rdv, 32'h00000004);
    repeat (2) @(negedge clk);
    chk("anytime outside six-phase", compareAnytime, 32'h0);
    apb(1'b1, A_CTRL, 32'h0000000e);
    repeat (2) @(negedge clk);
    chk("anytime six-phase", compareAnytime, 32'h1);
    apb(1'b1, A_OPT0, 32'h0);
    repeat (2) @(negedge clk);
    chk("batch six-phase", compareAnytime, 32'h0);
    apb(1'b1, A_OPT1, 32'h000000ff);
    apb(1'b0, A_OPT1, 32'h0);
    chk("option1 readback", rdv, 32'h000000df);
    apb(1'b1, A_OPT2, 32'h000000a5);
    apb(1'b0, A_OPT2, 32'h0);
    chk("option2 readback", rdv, 32'h000000a5);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped error", {rdv[30:0], errv}, 32'h1);
    apb(1'b1, A_PER, 32'h4);
    window(8'h80, 8'h82);
    cRef = 32'(evCnt[0]);
    chk("crest events seen", 32'(cRef >= 8), 32'h1);
    chk("valley disabled", evCnt[1], 32'h0);
    chk("crest trigger", evCnt[2], cRef);
    chk("transfers", evCnt[3], cRef);
    window(8'h83, 8'h82);
    chk("culled crest", evCnt[0], cRef / 4);
    chk("culled trigger", evCnt[2], cRef / 4);
    chk("culled transfers", evCnt[3], cRef / 4);
    window(8'hc0, 8'h01);
    chk("crest unculled", evCnt[0], cRef);
    chk("every transfer", evCnt[3], evCnt[0] + evCnt[1]);
    chk("valley trigger", evCnt[2], evCnt[1]);
    window(8'h40, 8'h01);
    chk("crest disabled", evCnt[0], 32'h0);
    apb(1'b1, A_OPT2, 32'h0);
    apb(1'b1, A_CTRL, 32'h0006000f);
    narrow(n0);
    chk("restart width", 32'(n0 >= 6), 32'h1);
    apb(1'b1, A_CTRL, 32'h0006000e);
    apb(1'b1, A_OPT2, 32'h00000040);
    apb(1'b1, A_CTRL, 32'h0006000f);
    narrow(n1);
    chk("narrowed width", 32'(n1 < n0), 32'h1);
    apb(1'b1, A_CTRL, 32'h0003000e);
    apb(1'b1, A_OPT2, 32'h0);
    apb(1'b1, A_CTRL, 32'h0003000f);
    repeat (20) @(posedge clk);
    phaseOutput[0] <= 1'b1;
    repeat (2) @(negedge clk);
    chk("dead time both off", armOut[0], 32'h0);
    repeat (8) @(negedge clk);
    chk("upper after dead time", armOut[0], 32'h2);
    @(posedge clk);
    phaseOutput[0] <= 1'b0;
    repeat (8) @(negedge clk);
    chk("lower after dead time", armOut[0], 32'h1);
    apb(1'b1, A_CTRL, 32'h0000000e);
    apb(1'b1, A_CTRL, 32'h0000000f);
    phaseOutput[0] <= 1'b1;
    repeat (3) @(negedge clk);
    chk("no dead time", armOut[0], 32'h2);
    apb(1'b1, A_CTRL, 32'h0000000e);
    repeat (3) @(negedge clk);
    chk("stopped arms", armOut, 32'h0);
    apb(1'b1, A_CTRL, 32'h0014000f);
    apb(1'b1, A_OPT0, 32'h00000004);
    apb(1'b0, A_OPT0, 32'h0);
    chk("rewrite while running", rdv & 32'h4, 32'h4);
    @(negedge clk);
    chk("anytime while running", compareAnytime, 32'h1);
    apb(1'b1, A_OPT0, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_OPT2, {24'h0, tSet[i]});
      clr();
      @(posedge clk);
      phaseOutput[0] <= ~phaseOutput[0];
      repeat (3) @(posedge clk);
      auxMatch0Irq <= ~tAux[i];
      auxMatch1Irq <= tAux[i];
      @(posedge clk);
      auxMatch0Irq <= 1'b0;
      auxMatch1Irq <= 1'b0;
      repeat (4) @(negedge clk);
      chk("aux trigger", evCnt[2], tExp[i]);
    end
    close_out();
  end
endmodule
